// ---- rtl/urm_pkg.sv ----
// Purpose: constants and types of the uart register map decode
// Assumes: one 8-byte window per channel, 3-bit offset
// Notes:   bit positions are plain ints, values are sized

package urm_pkg;

  // -------------------------------------------------------------------
  // window offsets
  // -------------------------------------------------------------------
  localparam int         WIN_BYTES  = 8;
  localparam int         WIN_AW     = 3;
  localparam logic [2:0] OFS_HOLD   = 3'h0;
  localparam logic [2:0] OFS_IEN    = 3'h1;
  localparam logic [2:0] OFS_FIFO   = 3'h2;
  localparam logic [2:0] OFS_LCTL   = 3'h3;
  localparam logic [2:0] OFS_MCTL   = 3'h4;
  localparam logic [2:0] OFS_LSTAT  = 3'h5;
  localparam logic [2:0] OFS_MSTAT  = 3'h6;
  localparam logic [2:0] OFS_SCR    = 3'h7;

  // -------------------------------------------------------------------
  // field positions and key values
  // -------------------------------------------------------------------
  localparam int         LC_DLAB    = 7;
  localparam int         AC_EXT     = 7;
  localparam int         AC_ICRRD   = 6;
  localparam int         LS_NINTH   = 2;
  localparam int         SC_NINTH   = 0;
  localparam logic [7:0] ENH_KEY    = 8'hbf;
  localparam logic [7:0] IDX_ACR    = 8'h00;
  localparam int         IDX_AW     = 4;
  localparam int         IDX_DEPTH  = 16;

  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [7:0]  RST_LCTL  = 8'h00;
  localparam logic [15:0] RST_DIV   = 16'h0000;
  localparam logic [7:0]  RST_IEN   = 8'h00;
  localparam logic [7:0]  RST_MCTL  = 8'h00;
  localparam logic [7:0]  RST_SCR   = 8'h00;
  localparam logic [7:0]  RST_ACR   = 8'h00;
  localparam logic [7:0]  RST_FCR   = 8'h00;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  // -------------------------------------------------------------------
  // decoded target of one access
  // -------------------------------------------------------------------
  typedef enum logic [13:0] {
    T_NONE  = 14'h0001,
    T_HOLD  = 14'h0002,
    T_DIVLO = 14'h0004,
    T_DIVHI = 14'h0008,
    T_IEN   = 14'h0010,
    T_FIFO  = 14'h0020,
    T_LCTL  = 14'h0040,
    T_MCTL  = 14'h0080,
    T_LSTAT = 14'h0100,
    T_MSTAT = 14'h0200,
    T_SCR   = 14'h0400,
    T_ICR   = 14'h0800,
    T_ENH   = 14'h1000,
    T_EXT   = 14'h2000
  } urm_tgt_type;

endpackage

// ---- rtl/urm_index_mem.sv ----
// Purpose: storage of the indexed control registers above index 0
// Assumes: one write or read per cycle, address already range checked
// Notes:   read data come out of a register one cycle after rd_en_i

`timescale 1ns/100ps

module urm_index_mem
  import urm_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic [IDX_AW-1:0] waddr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              rd_en_i,
  input  wire logic [IDX_AW-1:0] raddr_i,
  output logic      [7:0]        rdata_o
);
  import urm_pkg::*;

  logic [7:0] mem [IDX_DEPTH];
  logic [7:0] next_rdata;

  // -------------------------------------------------------------------
  // words
  // -------------------------------------------------------------------
  for (genvar g = 0; g < IDX_DEPTH; g++)
  begin : g_word
    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        mem[g] <= RST_BYTE;
      else if (wr_en_i && (waddr_i == IDX_AW'(g)))
        mem[g] <= wdata_i;
    end
  end

  // -------------------------------------------------------------------
  // registered read
  // -------------------------------------------------------------------
  always_comb
  begin
    next_rdata = rdata_o;
    if (rd_en_i)
      next_rdata = mem[raddr_i];
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= RST_BYTE;
    else
      rdata_o <= next_rdata;
  end

endmodule // urm_index_mem

// ---- rtl/urm_register_map_decode.sv ----
// Purpose: register window decode and standard registers of one uart
// Assumes: host strobes are synchronous to mclk_i, one cycle each
// Notes:   read data appear two cycles after rd_i with rdata_valid_o
// Overview of operation
// - The channel is one 8-byte window selected by a 3-bit offset.
// - With the divisor-latch bit set, offsets 0 and 1 reach the divisor.
// - One line control value gives the format of both directions.
// - Writing the key value to line control opens the enhanced set.
// - The key write sets only the divisor-latch bit and keeps bits 6..0.
// - With additional control bit 7 set, extended registers are mapped.
// - With additional control bit 6 set, indexed registers are readable.
// - Otherwise offset 0 writes transmit data and reads received data.
// - Offset 7 is a scratch byte that also holds the indexed address.
// - Registers other than the divisor and line control decode only when the last line write was no key.
// - The indexed window reaches the register the index names.

`timescale 1ns/100ps

module urm_register_map_decode
  import urm_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic [WIN_AW-1:0] addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [7:0]        rdata_o,
  output logic                   rdata_valid_o,
  output logic      [7:0]        tx_data_o,
  output logic                   tx_load_o,
  output logic                   tx_ninth_o,
  input  wire logic [7:0]        rx_data_i,
  input  wire logic              rx_ninth_i,
  output logic                   rx_pop_o,
  output logic      [7:0]        fifo_control_o,
  output logic                   fifo_control_load_o,
  input  wire logic [7:0]        interrupt_status_i,
  input  wire logic [7:0]        line_status_i,
  input  wire logic [7:0]        modem_status_i,
  input  wire logic              nine_bit_mode_i,
  output logic      [7:0]        line_control_o,
  output logic      [15:0]       baud_divisor_o,
  output logic      [7:0]        interrupt_enable_o,
  output logic      [7:0]        modem_control_o,
  output logic      [7:0]        additional_control_o,
  output logic      [7:0]        index_o,
  output logic                   enh_sel_o,
  output logic                   enh_wr_o,
  output logic                   enh_rd_o,
  input  wire logic [7:0]        enh_rdata_i,
  output logic                   ext_wr_o,
  output logic                   ext_rd_o,
  input  wire logic [7:0]        ext_rdata_i
);
  import urm_pkg::*;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  function automatic urm_tgt_type urm_decode(
    input logic [WIN_AW-1:0] ofs,
    input logic              is_wr,
    input logic              dlab,
    input logic              key,
    input logic              acr_ext,
    input logic              acr_icr
  );
    urm_tgt_type t;
    t = T_NONE;
    if (key)
    begin
      case (ofs)
        OFS_HOLD: t = T_DIVLO;
        OFS_IEN:  t = T_DIVHI;
        OFS_LCTL: t = T_LCTL;
        default:  t = T_ENH;
      endcase
    end
    else
    begin
      case (ofs)
        OFS_HOLD:  t = dlab ? T_DIVLO : T_HOLD;
        OFS_IEN:   t = dlab ? T_DIVHI : (acr_ext ? T_EXT : T_IEN);
        OFS_FIFO:  t = T_FIFO;
        OFS_LCTL:  t = (!is_wr && acr_ext) ? T_EXT : T_LCTL;
        OFS_MCTL:  t = (!is_wr && acr_ext) ? T_EXT : T_MCTL;
        OFS_LSTAT: t = (is_wr || acr_icr) ? T_ICR : T_LSTAT;
        OFS_MSTAT: t = is_wr ? T_NONE : T_MSTAT;
        OFS_SCR:   t = T_SCR;
        default:   t = T_NONE;
      endcase
    end
    return t;
  endfunction

  logic [7:0]  lctl;
  logic        key;
  logic [15:0] div;
  logic [7:0]  ien;
  logic [7:0]  mctl;
  logic [7:0]  scr;
  logic [7:0]  additional_control;
  logic [7:0]  transmit_holding;
  logic        thr_ld;
  logic [7:0]  fifo_control;
  logic        fcr_ld;
  logic [7:0]  next_lctl;
  logic        next_key;
  logic [15:0] next_div;
  logic [7:0]  next_ien;
  logic [7:0]  next_mctl;
  logic [7:0]  next_scr;
  logic [7:0]  next_acr;
  logic [7:0]  next_thr;
  logic        next_thr_ld;
  logic [7:0]  next_fcr;
  logic        next_fcr_ld;
  urm_tgt_type wr_tgt;
  urm_tgt_type rd_tgt;
  logic        idx_in_mem;
  logic        mem_wr;
  logic        mem_rd;
  logic [7:0]  mem_rdata;
  logic [7:0]  ls_view;
  logic [7:0]  rd_mux;
  logic        rd_q;
  logic        icr_q;
  logic [7:0]  hold;
  logic        next_rd_q;
  logic        next_icr_q;
  logic [7:0]  next_hold;
  logic [7:0]  next_rdata;

  assign wr_tgt = urm_decode(addr_i, 1'b1, lctl[LC_DLAB], key,
                             additional_control[AC_EXT], additional_control[AC_ICRRD]);
  assign rd_tgt = urm_decode(addr_i, 1'b0, lctl[LC_DLAB], key,
                             additional_control[AC_EXT], additional_control[AC_ICRRD]);

  // index 0 is the additional control register, indices 1 to 15 live in memory
  assign idx_in_mem = (scr != IDX_ACR) && (scr[7:IDX_AW] == 4'h0);
  assign mem_wr     = wr_i && (wr_tgt == T_ICR) && idx_in_mem;
  assign mem_rd     = rd_i && (rd_tgt == T_ICR) && idx_in_mem;

  // -------------------------------------------------------------------
  // writable registers
  // -------------------------------------------------------------------
  always_comb
  begin
    next_lctl   = lctl;
    next_key    = key;
    next_div    = div;
    next_ien    = ien;
    next_mctl   = mctl;
    next_scr    = scr;
    next_acr    = additional_control;
    next_thr    = transmit_holding;
    next_thr_ld = 1'b0;
    next_fcr    = fifo_control;
    next_fcr_ld = 1'b0;
    if (wr_i)
    begin
      case (wr_tgt)
        T_HOLD:
        begin
          next_thr    = wdata_i;
          next_thr_ld = 1'b1;
        end
        T_DIVLO: next_div[7:0]  = wdata_i;
        T_DIVHI: next_div[15:8] = wdata_i;
        T_IEN:   next_ien       = wdata_i;
        T_FIFO:
        begin
          next_fcr    = wdata_i;
          next_fcr_ld = 1'b1;
        end
        T_LCTL:
        begin
          if (wdata_i == ENH_KEY)
          begin
            next_lctl = {1'b1, lctl[6:0]};
            next_key  = 1'b1;
          end
          else
          begin
            next_lctl = wdata_i;
            next_key  = 1'b0;
          end
        end
        T_MCTL: next_mctl = wdata_i;
        T_SCR:  next_scr  = wdata_i;
        T_ICR:
        begin
          if (scr == IDX_ACR)
            next_acr = wdata_i;
        end
        default: next_scr = scr;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lctl   <= RST_LCTL;
      key    <= 1'b0;
      div    <= RST_DIV;
      ien    <= RST_IEN;
      mctl   <= RST_MCTL;
      scr    <= RST_SCR;
      additional_control    <= RST_ACR;
      transmit_holding    <= RST_BYTE;
      thr_ld <= 1'b0;
      fifo_control    <= RST_FCR;
      fcr_ld <= 1'b0;
    end
    else
    begin
      lctl   <= next_lctl;
      key    <= next_key;
      div    <= next_div;
      ien    <= next_ien;
      mctl   <= next_mctl;
      scr    <= next_scr;
      additional_control    <= next_acr;
      transmit_holding    <= next_thr;
      thr_ld <= next_thr_ld;
      fifo_control    <= next_fcr;
      fcr_ld <= next_fcr_ld;
    end
  end

  // -------------------------------------------------------------------
  // read path
  // -------------------------------------------------------------------
  always_comb
  begin
    ls_view = line_status_i;
    if (nine_bit_mode_i)
      ls_view[LS_NINTH] = rx_ninth_i;
    case (rd_tgt)
      T_HOLD:  rd_mux = rx_data_i;
      T_DIVLO: rd_mux = div[7:0];
      T_DIVHI: rd_mux = div[15:8];
      T_IEN:   rd_mux = ien;
      T_FIFO:  rd_mux = interrupt_status_i;
      T_LCTL:  rd_mux = lctl;
      T_MCTL:  rd_mux = mctl;
      T_LSTAT: rd_mux = ls_view;
      T_MSTAT: rd_mux = modem_status_i;
      T_SCR:   rd_mux = scr;
      T_ICR:   rd_mux = (scr == IDX_ACR) ? additional_control : RST_BYTE;
      T_ENH:   rd_mux = enh_rdata_i;
      T_EXT:   rd_mux = ext_rdata_i;
      default: rd_mux = RST_BYTE;
    endcase
    next_rd_q  = rd_i;
    next_icr_q = mem_rd;
    next_hold  = rd_i ? rd_mux : hold;
    next_rdata = rd_q ? (icr_q ? mem_rdata : hold) : rdata_o;
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_q          <= 1'b0;
      icr_q         <= 1'b0;
      hold          <= RST_BYTE;
      rdata_o       <= RST_BYTE;
      rdata_valid_o <= 1'b0;
    end
    else
    begin
      rd_q          <= next_rd_q;
      icr_q         <= next_icr_q;
      hold          <= next_hold;
      rdata_o       <= next_rdata;
      rdata_valid_o <= rd_q;
    end
  end

  urm_index_mem u_index_mem (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .wr_en_i (mem_wr),
    .waddr_i (scr[IDX_AW-1:0]),
    .wdata_i (wdata_i),
    .rd_en_i (mem_rd),
    .raddr_i (scr[IDX_AW-1:0]),
    .rdata_o (mem_rdata)
  );

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign tx_data_o            = transmit_holding;
  assign tx_load_o            = thr_ld;
  assign tx_ninth_o           = scr[SC_NINTH];
  assign rx_pop_o             = rd_i && (rd_tgt == T_HOLD);
  assign fifo_control_o       = fifo_control;
  assign fifo_control_load_o  = fcr_ld;
  assign line_control_o       = lctl;
  assign baud_divisor_o       = div;
  assign interrupt_enable_o   = ien;
  assign modem_control_o      = mctl;
  assign additional_control_o = additional_control;
  assign index_o              = scr;
  assign enh_sel_o            = key;
  assign enh_wr_o             = wr_i && (wr_tgt == T_ENH);
  assign enh_rd_o             = rd_i && (rd_tgt == T_ENH);
  assign ext_wr_o             = wr_i && (wr_tgt == T_EXT);
  assign ext_rd_o             = rd_i && (rd_tgt == T_EXT);

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  AST_RD_LATENCY: assert property (rd_i |-> ##2 rdata_valid_o)
    else $error("read answer not two cycles later");
  AST_DIV_LOW: assert property (wr_i && addr_i == OFS_HOLD && lctl[LC_DLAB]
    |=> baud_divisor_o[7:0] == $past(wdata_i) && !tx_load_o)
    else $error("divisor low write misrouted");
  AST_FMT_HOLD: assert property (!$stable(line_control_o)
    |-> $past(wr_i && addr_i == OFS_LCTL))
    else $error("line control changed without a write");
  AST_KEY_OPENS: assert property (wr_i && addr_i == OFS_LCTL
    && wdata_i == ENH_KEY && !(rd_i && addr_i == OFS_LCTL)
    |=> enh_sel_o)
    else $error("key write did not open enhanced set");
  AST_KEY_KEEPS: assert property (wr_i && addr_i == OFS_LCTL
    && wdata_i == ENH_KEY
    |=> line_control_o == {1'b1, $past(line_control_o[6:0])})
    else $error("key write disturbed the format bits");
  AST_EXT_MAP: assert property (rd_i && addr_i == OFS_LCTL && additional_control[AC_EXT]
    && !key |-> ext_rd_o)
    else $error("extended read not routed");
  AST_ICR_READ: assert property (rd_i && addr_i == OFS_LSTAT
    && additional_control[AC_ICRRD] && !key && scr == IDX_ACR
    |-> ##2 rdata_o == $past(additional_control_o, 2))
    else $error("indexed read of index 0 wrong");
  AST_THR_LOAD: assert property (wr_i && addr_i == OFS_HOLD && !lctl[LC_DLAB]
    |=> tx_load_o && tx_data_o == $past(wdata_i))
    else $error("transmit load missing");
  AST_RHR_READ: assert property (rd_i && addr_i == OFS_HOLD && !lctl[LC_DLAB]
    |-> rx_pop_o ##2 rdata_o == $past(rx_data_i, 2))
    else $error("receive read wrong");
  AST_SCR_WR: assert property (wr_i && addr_i == OFS_SCR && !key
    |=> index_o == $past(wdata_i)
    && tx_ninth_o == $past(wdata_i[SC_NINTH]))
    else $error("scratch write lost");
  AST_ENH_ROUTE: assert property (key && wr_i && addr_i == OFS_FIFO
    |-> enh_wr_o ##1 !fifo_control_load_o)
    else $error("normal register decoded under key");
  AST_ISR_READ: assert property (rd_i && addr_i == OFS_FIFO && !key
    |-> ##2 rdata_o == $past(interrupt_status_i, 2))
    else $error("interrupt status read wrong");
  AST_NINTH_RX: assert property (rd_i && addr_i == OFS_LSTAT && !key
    && !additional_control[AC_ICRRD] && nine_bit_mode_i
    |-> ##2 rdata_o[LS_NINTH] == $past(rx_ninth_i, 2))
    else $error("ninth receive bit missing");

  COV_KEY: cover property (wr_i && addr_i == OFS_LCTL && wdata_i == ENH_KEY);
  COV_ICR_MEM: cover property (mem_rd ##2 rdata_valid_o);
  COV_DIV: cover property (wr_i && wr_tgt == T_DIVHI);
  COV_EXIT: cover property (key ##1 !key);

endmodule // urm_register_map_decode

// ---- testbench/urm_host_model.sv ----
// Purpose: host side of the register window, one strobe per access
// Assumes: strobes launched off the falling edge of mclk_i
// Notes:   gap sets how slowly the host follows up

`timescale 1ns/100ps

module urm_host_model
  import urm_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic [7:0]        rdata_i,
  input  wire logic              rdata_valid_i,
  output logic      [WIN_AW-1:0] addr_o,
  output logic      [7:0]        wdata_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  initial
  begin
    addr_o = '0;
    wdata_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic bus_write(input logic [2:0] a, input logic [7:0] d,
                           input int gap);
    repeat (gap) @(negedge mclk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge mclk_i);
    wr_o = 1'b0;
    // released bus never keeps the last value
    wdata_o = ~d;
    addr_o = ~a;
  endtask

  task automatic bus_read(input logic [2:0] a, input int gap,
                          output logic [7:0] d, output int lat);
    int n;
    repeat (gap) @(negedge mclk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge mclk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = '0;
    lat = 0;
    // n counts edges after the strobe edge; look between edges
    for (n = 2; n <= 7 && lat == 0; n++)
    begin
      @(negedge mclk_i);
      if (rdata_valid_i === 1'b1)
      begin
        lat = n;
        d = rdata_i;
      end
    end
  endtask
endmodule // urm_host_model

// ---- testbench/uart_register_map_decode_tb.sv ----
// Purpose: self-checking bench of the uart register map decode
// Assumes: host and engine inputs change at the falling edge
// Notes:   integer model compared at every read and write

`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("unexpected at %0t got %h exp %h", $time, g, e); \
    end \
  end

module uart_register_map_decode_tb;
  import urm_pkg::*;
  logic mclk_i, rst_n_i, wr_i, rd_i, rdata_valid_o, tx_load_o, tx_ninth_o;
  logic rx_ninth_i, rx_pop_o, fifo_control_load_o, nine_bit_mode_i;
  logic enh_sel_o, enh_wr_o, enh_rd_o, ext_wr_o, ext_rd_o;
  logic [WIN_AW-1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, tx_data_o, rx_data_i, fifo_control_o;
  logic [7:0] interrupt_status_i, line_status_i, modem_status_i;
  logic [7:0] line_control_o, interrupt_enable_o, modem_control_o;
  logic [7:0] additional_control_o, index_o, enh_rdata_i, ext_rdata_i;
  logic [15:0] baud_divisor_o, seed;
  logic [7:0] m_lcr, m_ien, m_mcr, m_scr, m_acr, m_tx, m_fcr;
  logic [7:0] m_mem [16];
  logic [15:0] m_div;
  logic m_key;
  int n_tx, n_fcl, n_pop, n_enw, n_exw, e_tx, e_fcl, e_pop, e_enw, e_exw;
  int n_errors, comparisons;
  logic [11:0] dir_ops [32] = '{12'h31b, 12'h3bf, 12'hb00, 12'h034,
    12'h112, 12'h577, 12'h800, 12'h900, 12'hd00, 12'h303,
    12'hb00, 12'h055, 12'h800, 12'h700, 12'h5c0, 12'h900, 12'hb00,
    12'hd00, 12'h703, 12'h5a5, 12'hd00, 12'h720, 12'h511, 12'hd00,
    12'h700, 12'h500, 12'hd00, 12'he00, 12'ha00, 12'h2c7, 12'h6ee,
    12'hf00};

  urm_register_map_decode dut (.mclk_i, .rst_n_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .rdata_valid_o, .tx_data_o, .tx_load_o,
    .tx_ninth_o, .rx_data_i, .rx_ninth_i, .rx_pop_o, .fifo_control_o,
    .fifo_control_load_o, .interrupt_status_i, .line_status_i,
    .modem_status_i, .nine_bit_mode_i, .line_control_o, .baud_divisor_o,
    .interrupt_enable_o, .modem_control_o, .additional_control_o,
    .index_o, .enh_sel_o, .enh_wr_o, .enh_rd_o, .enh_rdata_i, .ext_wr_o,
    .ext_rd_o, .ext_rdata_i);

  urm_host_model host (.mclk_i(mclk_i), .rdata_i(rdata_o),
    .rdata_valid_i(rdata_valid_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i));

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i)
    if (rst_n_i)
    begin
      n_tx += (tx_load_o === 1'b1);
      n_fcl += (fifo_control_load_o === 1'b1);
      n_pop += (rx_pop_o === 1'b1);
      n_enw += (enh_wr_o === 1'b1) + (enh_rd_o === 1'b1);
      n_exw += (ext_wr_o === 1'b1) + (ext_rd_o === 1'b1);
    end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic lcr_wr(input logic [7:0] d);
    m_key = (d == ENH_KEY);
    if (m_key) m_lcr[7] = 1'b1;
    else m_lcr = d;
  endtask

  task automatic mdl_write(input logic [2:0] a, input logic [7:0] d);
    if (m_key)
      case (a)
        3'h0: m_div[7:0] = d;
        3'h1: m_div[15:8] = d;
        3'h3: lcr_wr(d);
        default: e_enw++;
      endcase
    else
      case (a)
        3'h0: if (m_lcr[7]) m_div[7:0] = d; else
        begin
          m_tx = d;
          e_tx++;
        end
        3'h1: if (m_lcr[7]) m_div[15:8] = d; else if (m_acr[7]) e_exw++;
              else m_ien = d;
        3'h2:
        begin
          m_fcr = d;
          e_fcl++;
        end
        3'h3: lcr_wr(d);
        3'h4: m_mcr = d;
        3'h5: if (m_scr == 8'h00) m_acr = d;
              else if (m_scr < 8'h10) m_mem[m_scr[3:0]] = d;
        3'h7: m_scr = d;
        default: ;
      endcase
  endtask

  function automatic logic [7:0] mdl_read(input logic [2:0] a);
    logic [7:0] ls;
    logic [7:0] ix;
    ls = line_status_i;
    if (nine_bit_mode_i) ls[2] = rx_ninth_i;
    ix = (m_scr == 8'h00) ? m_acr :
         (m_scr < 8'h10) ? m_mem[m_scr[3:0]] : 8'h00;
    if (m_key)
      return (a == 3'h0) ? m_div[7:0] : (a == 3'h1) ? m_div[15:8] :
             (a == 3'h3) ? m_lcr : enh_rdata_i;
    case (a)
      3'h0: return m_lcr[7] ? m_div[7:0] : rx_data_i;
      3'h1: return m_lcr[7] ? m_div[15:8] : m_acr[7] ? ext_rdata_i : m_ien;
      3'h2: return interrupt_status_i;
      3'h3: return m_acr[7] ? ext_rdata_i : m_lcr;
      3'h4: return m_acr[7] ? ext_rdata_i : m_mcr;
      3'h5: return m_acr[6] ? ix : ls;
      3'h6: return modem_status_i;
      default: return m_scr;
    endcase
  endfunction

  task automatic check_regs;
    `CHK(line_control_o, m_lcr)
    `CHK(baud_divisor_o, m_div)
    `CHK(interrupt_enable_o, m_ien)
    `CHK(modem_control_o, m_mcr)
    `CHK(additional_control_o, m_acr)
    `CHK(index_o, m_scr)
    `CHK(enh_sel_o, m_key)
    `CHK(tx_ninth_o, m_scr[0])
    `CHK(tx_data_o, m_tx)
    `CHK(fifo_control_o, m_fcr)
    `CHK(n_tx, e_tx)
    `CHK(n_fcl, e_fcl)
    `CHK(n_pop, e_pop)
    `CHK(n_enw, e_enw)
    `CHK(n_exw, e_exw)
  endtask

  task automatic op(input logic rd, input logic [2:0] a,
                    input logic [7:0] d);
    logic [7:0] e;
    logic [7:0] got;
    int lat;
    @(negedge mclk_i);
    seed = lfsr(seed);
    {rx_data_i, interrupt_status_i} = seed;
    seed = lfsr(seed);
    {line_status_i, modem_status_i} = seed;
    seed = lfsr(seed);
    {enh_rdata_i, ext_rdata_i} = seed;
    rx_ninth_i = seed[3];
    nine_bit_mode_i = seed[9];
    if (!rd)
    begin
      host.bus_write(a, d, int'(seed[1:0]));
      mdl_write(a, d);
      @(posedge mclk_i);
      #1;
      check_regs();
    end
    else
    begin
      e = mdl_read(a);
      e_pop += (!m_key && a == 3'h0 && !m_lcr[7]);
      e_enw += (m_key && a != 3'h0 && a != 3'h1 && a != 3'h3);
      e_exw += (!m_key && m_acr[7] && (a == 3'h3 || a == 3'h4 ||
                (a == 3'h1 && !m_lcr[7])));
      host.bus_read(a, int'(seed[1:0]), got, lat);
      `CHK(got, e)
      `CHK(lat, 2)
    end
  endtask

  task automatic complete_run;
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    logic [15:0] r;
    rst_n_i = 1'b0;
    {rx_data_i, interrupt_status_i, line_status_i, modem_status_i} = '0;
    {enh_rdata_i, ext_rdata_i, rx_ninth_i, nine_bit_mode_i} = '0;
    // lfsr starts at 12363
    seed = 16'h304b;
    {m_lcr, m_ien, m_mcr, m_scr, m_acr, m_tx, m_fcr, m_div, m_key} = '0;
    foreach (m_mem[i]) m_mem[i] = 8'h00;
    {n_tx, n_fcl, n_pop, n_enw, n_exw, e_tx, e_fcl, e_pop} = '0;
    {e_enw, e_exw, n_errors, comparisons} = '0;
    repeat (4) @(negedge mclk_i);
    rst_n_i = 1'b1;
    check_regs();
    foreach (dir_ops[i]) op(dir_ops[i][11], dir_ops[i][10:8], dir_ops[i][7:0]);
    repeat (400)
    begin
      seed = lfsr(seed);
      r = seed;
      seed = lfsr(seed);
      if (r[6:4] == 3'h0) op(1'b0, OFS_LCTL, ENH_KEY);
      else op(r[0], r[3:1], (r[3:1] == OFS_SCR && r[7]) ?
              {4'h0, seed[3:0]} : seed[15:8]);
    end
    check_regs();
    complete_run();
  end
endmodule // uart_register_map_decode_tb
